// File: sesr_status_core.sv
// Overview of operation
// - Trigger set B1 on layer entry/exit edge
// - Arm set B1 on arm layer edges
// - Sequence B1 follows arm layer one edges
// - Sequence B2 follows arm layer two edges
// - All other layer event bits stay zero
// - Enable zero masks event from summary
// - Enable one passes event to summary
// - Written decimal weight sum becomes enable image
// - Enable query returns present enable contents
// - Six separately programmable enable registers
// - Measurement enable bits match measurement weights
// - Questionable enable uses B4,B8,B14; B15 zero
// - Operation enable uses B0,B1,B5,B6,B10
// - Trigger enable uses only B1
// - Arm enable uses only B1
// - Sequence enable uses only B1, B2
// - Rising condition edge sets event if rising filter bit set
// - Operation B5, B6 fed by layer summaries
`timescale 1ns/100ps
module sesr_status_core
    import sesr_pkg::*;
(
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic             i_cmd_valid,
    input  wire sesr_cmd_type     i_cmd,
    input  wire logic             i_trig_layer_active,
    input  wire logic             i_arm_layer_active,
    input  wire logic             i_arm_level_one,
    input  wire logic             i_arm_level_two,
    input  wire logic [REG_W-1:0] i_meas_events,
    input  wire logic [REG_W-1:0] i_ques_events,
    input  wire logic [REG_W-1:0] i_oper_events,
    output logic                  o_rsp_valid,
    output logic      [REG_W-1:0] o_rsp_data,
    output logic      [REG_W-1:0] o_trigger_layer_events,
    output logic      [REG_W-1:0] o_arm_layer_events,
    output logic      [REG_W-1:0] o_arm_sequence_layer_events,
    output sesr_summary_type      o_summary
);

    logic [COND_W-1:0] pin_async;
    logic [COND_W-1:0] pin_sync;
    logic [REG_W-1:0]  trig_cond;
    logic [REG_W-1:0]  arm_cond;
    logic [REG_W-1:0]  seq_cond;

    logic [REG_W-1:0]  measurement_event_mask_ff;
    logic [REG_W-1:0]  questionable_event_mask_ff;
    logic [REG_W-1:0]  operation_event_mask_ff;
    logic [REG_W-1:0]  trigger_layer_event_mask_ff;
    logic [REG_W-1:0]  arm_layer_event_mask_ff;
    logic [REG_W-1:0]  arm_sequence_event_mask_ff;

    logic [REG_W-1:0]  trig_rising_ff;
    logic [REG_W-1:0]  arm_rising_ff;
    logic [REG_W-1:0]  seq_rising_ff;
    logic [REG_W-1:0]  trig_falling_filter_ff;
    logic [REG_W-1:0]  arm_falling_filter_ff;
    logic [REG_W-1:0]  seq_falling_filter_ff;

    logic              rsp_valid_ff;
    logic [REG_W-1:0]  rsp_data_ff;
    sesr_summary_type  summary_ff;
    sesr_summary_type  nxt_summary;
    logic [REG_W-1:0]  nxt_rsp_data;
    logic [REG_W-1:0]  oper_effective;

    logic              cmd_wr;
    logic              cmd_rd;
    logic              clr_trig;
    logic              clr_arm;
    logic              clr_seq;

    assign cmd_wr = i_cmd_valid && i_cmd.write;
    assign cmd_rd = i_cmd_valid && !i_cmd.write;

    // Reading an event register empties it, as a status query does
    assign clr_trig = cmd_rd && (i_cmd.target == TGT_EVT_TRIG);
    assign clr_arm  = cmd_rd && (i_cmd.target == TGT_EVT_ARM);
    assign clr_seq  = cmd_rd && (i_cmd.target == TGT_EVT_SEQ);

    // Layer state arrives from the trigger sequencer pins
    assign pin_async = {i_arm_level_two, i_arm_level_one, i_arm_layer_active,
                        i_trig_layer_active};

    sesr_sync #(
        .WIDTH (COND_W)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_async    (pin_async),
        .o_sync     (pin_sync)
    );

    always_comb begin
        trig_cond           = ZERO_WORD;
        arm_cond            = ZERO_WORD;
        seq_cond            = ZERO_WORD;
        trig_cond[GROUP_ONE_BIT] = pin_sync[0];
        arm_cond[GROUP_ONE_BIT]  = pin_sync[1];
        seq_cond[LEVEL_ONE_BIT]  = pin_sync[2];
        seq_cond[LEVEL_TWO_BIT]  = pin_sync[3];
    end

    sesr_event_set #(
        .USED (TRIG_USED)
    ) u_trig_events (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_cond     (trig_cond),
        .i_ptr      (trig_rising_ff),
        .i_fall_en  (trig_falling_filter_ff),
        .i_clear    (clr_trig),
        .o_events   (o_trigger_layer_events)
    );

    sesr_event_set #(
        .USED (ARM_USED)
    ) u_arm_events (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_cond     (arm_cond),
        .i_ptr      (arm_rising_ff),
        .i_fall_en  (arm_falling_filter_ff),
        .i_clear    (clr_arm),
        .o_events   (o_arm_layer_events)
    );

    sesr_event_set #(
        .USED (SEQ_USED)
    ) u_seq_events (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_cond     (seq_cond),
        .i_ptr      (seq_rising_ff),
        .i_fall_en  (seq_falling_filter_ff),
        .i_clear    (clr_seq),
        .o_events   (o_arm_sequence_layer_events)
    );

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            measurement_event_mask_ff   <= ENABLE_RESET;
            questionable_event_mask_ff  <= ENABLE_RESET;
            operation_event_mask_ff     <= ENABLE_RESET;
            trigger_layer_event_mask_ff <= ENABLE_RESET;
            arm_layer_event_mask_ff     <= ENABLE_RESET;
            arm_sequence_event_mask_ff  <= ENABLE_RESET;
        end else if (cmd_wr) begin
            unique case (i_cmd.target)
                TGT_ENA_MEAS: measurement_event_mask_ff   <= i_cmd.data & MEAS_USED;
                TGT_ENA_QUES: questionable_event_mask_ff  <= i_cmd.data & QUES_USED;
                TGT_ENA_OPER: operation_event_mask_ff     <= i_cmd.data & OPER_USED;
                TGT_ENA_TRIG: trigger_layer_event_mask_ff <= i_cmd.data & TRIG_USED;
                TGT_ENA_ARM:  arm_layer_event_mask_ff     <= i_cmd.data & ARM_USED;
                TGT_ENA_SEQ:  arm_sequence_event_mask_ff  <= i_cmd.data & SEQ_USED;
                default: begin
                end
            endcase
        end
    end

    // Filters preset to catch rising edges only
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            // Reset image trimmed so a query never shows unused bits
            trig_rising_ff         <= PTR_RESET & TRIG_USED;
            arm_rising_ff          <= PTR_RESET & ARM_USED;
            seq_rising_ff          <= PTR_RESET & SEQ_USED;
            trig_falling_filter_ff <= FALL_RESET;
            arm_falling_filter_ff  <= FALL_RESET;
            seq_falling_filter_ff  <= FALL_RESET;
        end else if (cmd_wr) begin
            unique case (i_cmd.target)
                TGT_PTR_TRIG: trig_rising_ff         <= i_cmd.data & TRIG_USED;
                TGT_PTR_ARM:  arm_rising_ff          <= i_cmd.data & ARM_USED;
                TGT_PTR_SEQ:  seq_rising_ff          <= i_cmd.data & SEQ_USED;
                TGT_FALL_TRIG: trig_falling_filter_ff <= i_cmd.data & TRIG_USED;
                TGT_FALL_ARM:  arm_falling_filter_ff  <= i_cmd.data & ARM_USED;
                TGT_FALL_SEQ:  seq_falling_filter_ff  <= i_cmd.data & SEQ_USED;
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        nxt_rsp_data = ZERO_WORD;
        unique case (i_cmd.target)
            TGT_ENA_MEAS: nxt_rsp_data = measurement_event_mask_ff;
            TGT_ENA_QUES: nxt_rsp_data = questionable_event_mask_ff;
            TGT_ENA_OPER: nxt_rsp_data = operation_event_mask_ff;
            TGT_ENA_TRIG: nxt_rsp_data = trigger_layer_event_mask_ff;
            TGT_ENA_ARM:  nxt_rsp_data = arm_layer_event_mask_ff;
            TGT_ENA_SEQ:  nxt_rsp_data = arm_sequence_event_mask_ff;
            TGT_EVT_TRIG: nxt_rsp_data = o_trigger_layer_events;
            TGT_EVT_ARM:  nxt_rsp_data = o_arm_layer_events;
            TGT_EVT_SEQ:  nxt_rsp_data = o_arm_sequence_layer_events;
            TGT_PTR_TRIG: nxt_rsp_data = trig_rising_ff;
            TGT_PTR_ARM:  nxt_rsp_data = arm_rising_ff;
            TGT_PTR_SEQ:  nxt_rsp_data = seq_rising_ff;
            TGT_FALL_TRIG: nxt_rsp_data = trig_falling_filter_ff;
            TGT_FALL_ARM:  nxt_rsp_data = arm_falling_filter_ff;
            TGT_FALL_SEQ:  nxt_rsp_data = seq_falling_filter_ff;
            default:      nxt_rsp_data = ZERO_WORD;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff  <= ZERO_WORD;
        end else begin
            rsp_valid_ff <= cmd_rd;
            if (cmd_rd) begin
                rsp_data_ff <= nxt_rsp_data;
            end
        end
    end

    always_comb begin
        nxt_summary.trig = |(o_trigger_layer_events & trigger_layer_event_mask_ff);
        nxt_summary.arm  = |(o_arm_layer_events & arm_layer_event_mask_ff);
        nxt_summary.seq  = |(o_arm_sequence_layer_events & arm_sequence_event_mask_ff);
        oper_effective                = i_oper_events;
        oper_effective[OPER_TRIG_BIT] = i_oper_events[OPER_TRIG_BIT] | nxt_summary.trig;
        oper_effective[OPER_ARM_BIT]  = i_oper_events[OPER_ARM_BIT] | nxt_summary.arm;
        nxt_summary.oper = |(oper_effective & operation_event_mask_ff);
        nxt_summary.meas = |(i_meas_events & measurement_event_mask_ff);
        nxt_summary.ques = |(i_ques_events & questionable_event_mask_ff);
    end

    // One cycle of latency keeps every output on a flip-flop
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            summary_ff <= '0;
        end else begin
            summary_ff <= nxt_summary;
        end
    end

    assign o_rsp_valid = rsp_valid_ff;
    assign o_rsp_data  = rsp_data_ff;
    assign o_summary   = summary_ff;

    a_mask_blocks: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        !trigger_layer_event_mask_ff[GROUP_ONE_BIT] |=> !o_summary.trig)
        else $error("Masked trigger event reached summary");

    a_mask_passes: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        trigger_layer_event_mask_ff[GROUP_ONE_BIT] && o_trigger_layer_events[GROUP_ONE_BIT]
        |=> o_summary.trig)
        else $error("Enabled trigger event missing from summary");

    a_enable_load: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        cmd_wr && (i_cmd.target == TGT_ENA_MEAS)
        |=> measurement_event_mask_ff == ($past(i_cmd.data) & MEAS_USED))
        else $error("Measurement enable image not loaded");

    a_query_returns: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        cmd_rd && (i_cmd.target == TGT_ENA_OPER)
        |=> o_rsp_valid && (o_rsp_data == $past(operation_event_mask_ff)))
        else $error("Operation enable query returned wrong value");

    a_rise_sets: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(trig_cond[GROUP_ONE_BIT]) && trig_rising_ff[GROUP_ONE_BIT]
        |=> o_trigger_layer_events[GROUP_ONE_BIT])
        else $error("Rising trigger layer edge not captured");

    a_arm_rise: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(arm_cond[GROUP_ONE_BIT]) && arm_rising_ff[GROUP_ONE_BIT]
        |=> o_arm_layer_events[GROUP_ONE_BIT])
        else $error("Rising arm layer edge not captured");

    a_level_one_rise: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(seq_cond[LEVEL_ONE_BIT]) && seq_rising_ff[LEVEL_ONE_BIT]
        |=> o_arm_sequence_layer_events[LEVEL_ONE_BIT])
        else $error("Rising arm level one edge not captured");

    a_answer_pulse: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_rsp_valid == $past(cmd_rd))
        else $error("Query answer strobe misplaced");

    a_meas_passes: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        |(i_meas_events & measurement_event_mask_ff) |=> o_summary.meas)
        else $error("Enabled measurement event missing from summary");

    a_fall_sets: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(seq_cond[LEVEL_TWO_BIT]) && seq_falling_filter_ff[LEVEL_TWO_BIT]
        |=> o_arm_sequence_layer_events[LEVEL_TWO_BIT])
        else $error("Falling arm level two edge not captured");

    a_event_sticky: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        o_arm_layer_events[GROUP_ONE_BIT] && !clr_arm |=> o_arm_layer_events[GROUP_ONE_BIT])
        else $error("Arm event dropped without a clear");

    a_unused_zero: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        ((o_arm_sequence_layer_events & ~SEQ_USED) == ZERO_WORD)
        && ((o_trigger_layer_events & ~TRIG_USED) == ZERO_WORD))
        else $error("Unused layer event bit set");

    a_ques_top_zero: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        cmd_wr && (i_cmd.target == TGT_ENA_QUES) |=> !questionable_event_mask_ff[REG_W-1])
        else $error("Questionable enable B15 not zero");

    a_oper_feed: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        operation_event_mask_ff[OPER_TRIG_BIT] && trigger_layer_event_mask_ff[GROUP_ONE_BIT]
        && o_trigger_layer_events[GROUP_ONE_BIT] |=> o_summary.oper)
        else $error("Trigger summary did not reach operation summary");

endmodule : sesr_status_core

// File: sesr_pkg.sv
package sesr_pkg;

    localparam int unsigned REG_W          = 16;
    localparam int unsigned COND_W         = 4;

    // Bit positions inside the layer event sets and the operation register
    localparam int unsigned GROUP_ONE_BIT  = 1;
    localparam int unsigned LEVEL_ONE_BIT  = 1;
    localparam int unsigned LEVEL_TWO_BIT  = 2;
    localparam int unsigned OPER_TRIG_BIT  = 5;
    localparam int unsigned OPER_ARM_BIT   = 6;

    // Implemented bits of each enable image
    localparam logic [15:0] MEAS_USED      = 16'h0BBF;
    localparam logic [15:0] QUES_USED      = 16'h4110;
    localparam logic [15:0] OPER_USED      = 16'h0463;
    localparam logic [15:0] TRIG_USED      = 16'h0002;
    localparam logic [15:0] ARM_USED       = 16'h0002;
    localparam logic [15:0] SEQ_USED       = 16'h0006;

    localparam logic [15:0] ENABLE_RESET   = 16'h0000;
    localparam logic [15:0] PTR_RESET      = 16'hFFFF;
    localparam logic [15:0] FALL_RESET     = 16'h0000;
    localparam logic [15:0] ZERO_WORD      = 16'h0000;

    typedef enum logic [3:0] {
        TGT_ENA_MEAS,
        TGT_ENA_QUES,
        TGT_ENA_OPER,
        TGT_ENA_TRIG,
        TGT_ENA_ARM,
        TGT_ENA_SEQ,
        TGT_EVT_TRIG,
        TGT_EVT_ARM,
        TGT_EVT_SEQ,
        TGT_PTR_TRIG,
        TGT_PTR_ARM,
        TGT_PTR_SEQ,
        TGT_FALL_TRIG,
        TGT_FALL_ARM,
        TGT_FALL_SEQ
    } sesr_target_type;

    typedef struct packed {
        logic            write;
        sesr_target_type target;
        logic [15:0]     data;
    } sesr_cmd_type;

    typedef struct packed {
        logic meas;
        logic ques;
        logic oper;
        logic trig;
        logic arm;
        logic seq;
    } sesr_summary_type;

endpackage : sesr_pkg

// File: sesr_sync.sv
`timescale 1ns/100ps
module sesr_sync
    import sesr_pkg::*;
#(
    parameter int unsigned WIDTH = COND_W
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // First stage feeds only the second stage
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule : sesr_sync

// File: sesr_event_set.sv
`timescale 1ns/100ps
module sesr_event_set
    import sesr_pkg::*;
#(
    parameter logic [15:0] USED = TRIG_USED
) (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    input  wire logic [15:0] i_cond,
    input  wire logic [15:0] i_ptr,
    input  wire logic [15:0] i_fall_en,
    input  wire logic        i_clear,
    output logic      [15:0] o_events
);

    logic [15:0] prev_ff;
    logic [15:0] events_ff;
    logic [15:0] nxt_set;

    always_comb begin
        nxt_set = ((i_cond & ~prev_ff & i_ptr) | (~i_cond & prev_ff & i_fall_en)) & USED;
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            prev_ff <= ZERO_WORD;
        end else begin
            prev_ff <= i_cond;
        end
    end

    // Set wins over a clear in the same cycle so no edge is lost
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            events_ff <= ZERO_WORD;
        end else if (i_clear) begin
            events_ff <= nxt_set;
        end else begin
            events_ff <= events_ff | nxt_set;
        end
    end

    assign o_events = events_ff;

endmodule : sesr_event_set

// File: status_event_enable_structure_test.sv
`timescale 1ns/100ps
module status_event_enable_structure_test
    import sesr_pkg::*;
;
    logic              i_core_clk;
    logic              i_rst;
    logic              i_cmd_valid;
    sesr_cmd_type      i_cmd;
    logic [3:0]        pins;
    logic [15:0]       meas_ev;
    logic [15:0]       ques_ev;
    logic [15:0]       oper_ev;
    logic              o_rsp_valid;
    logic [15:0]       o_rsp_data;
    logic [15:0]       o_trigger_layer_events;
    logic [15:0]       o_arm_layer_events;
    logic [15:0]       o_arm_sequence_layer_events;
    sesr_summary_type  o_summary;
    int                n_mismatch;
    int                tests_run;
    int                seed;
    logic [15:0]       exp_q[$];
    logic [15:0]       used_tab[6];
    logic [15:0]       val[6];
    logic [15:0]       en_m;
    logic [15:0]       en_q;
    logic [15:0]       en_o;

    always #25 i_core_clk = ~i_core_clk;

    sesr_status_core u_sesr_status_core (
        .i_core_clk                  (i_core_clk),
        .i_rst                       (i_rst),
        .i_cmd_valid                 (i_cmd_valid),
        .i_cmd                       (i_cmd),
        .i_trig_layer_active         (pins[0]),
        .i_arm_layer_active          (pins[1]),
        .i_arm_level_one             (pins[2]),
        .i_arm_level_two             (pins[3]),
        .i_meas_events               (meas_ev),
        .i_ques_events               (ques_ev),
        .i_oper_events               (oper_ev),
        .o_rsp_valid                 (o_rsp_valid),
        .o_rsp_data                  (o_rsp_data),
        .o_trigger_layer_events      (o_trigger_layer_events),
        .o_arm_layer_events          (o_arm_layer_events),
        .o_arm_sequence_layer_events (o_arm_sequence_layer_events),
        .o_summary                   (o_summary)
    );

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report;
        if (exp_q.size() != 0) begin
            n_mismatch++;
        end
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    // Queries note their answer; writes expect none
    task automatic send(input logic wr, input int tgt, input logic [15:0] data,
                        input logic [15:0] exp);
        @(negedge i_core_clk);
        i_cmd_valid   = 1'b1;
        i_cmd.write   = wr;
        i_cmd.target  = sesr_target_type'(tgt[3:0]);
        i_cmd.data    = data;
        if (!wr) begin
            exp_q.push_back(exp);
        end
    endtask : send

    task automatic idle;
        @(negedge i_core_clk);
        i_cmd_valid = 1'b0;
    endtask : idle

    task automatic wait_neg(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : wait_neg

    function automatic logic [15:0] ev_of(input int k);
        return (k == 0) ? o_trigger_layer_events :
               (k == 1) ? o_arm_layer_events : o_arm_sequence_layer_events;
    endfunction : ev_of

    function automatic logic [15:0] sum_of(input int k);
        return {15'h0000, (k == 0) ? o_summary.trig : (k == 1) ? o_summary.arm : o_summary.seq};
    endfunction : sum_of

    // Answer checker; a stray answer counts as a mismatch
    always @(negedge i_core_clk) begin
        if (o_rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("CHECK FAILED rsp_data expected none seen %h", o_rsp_data);
            end else begin
                check("rsp_data", o_rsp_data, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20000) @(posedge i_core_clk);
        n_mismatch++;
        $display("CHECK FAILED watchdog expected end seen hang");
        final_report();
    end

    initial begin
        int k;
        int kk;
        logic [15:0] bv;
        i_core_clk  = 1'b0;
        i_rst       = 1'b1;
        i_cmd_valid = 1'b0;
        i_cmd       = '0;
        pins        = 4'h0;
        meas_ev     = 16'h0000;
        ques_ev     = 16'h0000;
        oper_ev     = 16'h0000;
        seed        = 4;
        used_tab    = '{MEAS_USED, QUES_USED, OPER_USED, TRIG_USED, ARM_USED, SEQ_USED};
        repeat (2) @(negedge i_core_clk);
        i_rst = 1'b0;
        // Reset images clear except rising filters, unmapped code answers zero
        for (int t = 0; t < 15; t++) begin
            bv = (t > 8 && t < 12) ? (PTR_RESET & used_tab[t - 6]) : 16'h0000;
            send(1'b0, t, 16'h0000, bv);
        end
        send(1'b0, 15, 16'h0000, 16'h0000);
        idle();
        check("summary", {10'h000, o_summary}, 16'h0000);
        // all-ones and zero weight sums, back to back
        for (int t = 0; t < 6; t++) begin
            send(1'b1, t, 16'hFFFF, 16'h0000);
            send(1'b0, t, 16'h0000, used_tab[t]);
            send(1'b1, t, 16'h0000, 16'h0000);
            send(1'b0, t, 16'h0000, 16'h0000);
        end
        send(1'b1, 0, 16'h0220, 16'h0000);
        send(1'b0, 0, 16'h0000, 16'h0220);
        send(1'b1, 2, 16'h0202, 16'h0000);
        send(1'b0, 2, 16'h0000, 16'h0002);
        for (int t = 0; t < 6; t++) begin
            val[t] = 16'($random(seed));
            send(1'b1, t, val[t], 16'h0000);
        end
        for (int t = 0; t < 6; t++) send(1'b0, t, 16'h0000, val[t] & used_tab[t]);
        send(1'b1, 6, 16'hFFFF, 16'h0000);
        send(1'b0, 6, 16'h0000, 16'h0000);
        send(1'b1, 15, 16'hFFFF, 16'h0000);
        send(1'b0, 15, 16'h0000, 16'h0000);
        idle();
        for (int i = 0; i < 24; i++) begin
            en_m = 16'($random(seed));
            en_q = 16'($random(seed));
            en_o = 16'($random(seed)) & 16'hFF9F;
            send(1'b1, 0, en_m, 16'h0000);
            send(1'b1, 1, en_q, 16'h0000);
            send(1'b1, 2, en_o, 16'h0000);
            idle();
            meas_ev = 16'($random(seed) & $random(seed) & $random(seed));
            ques_ev = 16'($random(seed) & $random(seed));
            oper_ev = 16'($random(seed) & $random(seed));
            wait_neg(2);
            check("sum_meas", {15'h0000, o_summary.meas}, {15'h0000, |(meas_ev & en_m & MEAS_USED)});
            check("sum_ques", {15'h0000, o_summary.ques}, {15'h0000, |(ques_ev & en_q & QUES_USED)});
            check("sum_oper", {15'h0000, o_summary.oper}, {15'h0000, |(oper_ev & en_o & OPER_USED)});
        end
        oper_ev = 16'h0000;
        send(1'b1, 0, 16'h0000, 16'h0000);
        send(1'b1, 1, 16'h0000, 16'h0000);
        send(1'b1, 2, 16'h0060, 16'h0000);
        // Layer enables still hold random images from the hold-apart test
        for (int t = 3; t < 6; t++) send(1'b1, t, 16'h0000, 16'h0000);
        idle();
        // Layer pins: rising edge, masking, read clear, falling edge
        for (k = 0; k < 4; k++) begin
            kk = (k > 2) ? 2 : k;
            bv = (k == 3) ? 16'h0004 : 16'h0002;
            wait_neg(1);
            pins[k] = 1'b1;
            wait_neg(4);
            check("event_rise", ev_of(k), bv);
            check("sum_masked", sum_of(k), 16'h0000);
            send(1'b1, 3 + kk, bv, 16'h0000);
            idle();
            wait_neg(1);
            check("sum_pass", sum_of(k), 16'h0001);
            check("sum_oper", {15'h0000, o_summary.oper}, {15'h0000, k < 2});
            send(1'b0, 6 + kk, 16'h0000, bv);
            idle();
            check("event_clear", ev_of(k), 16'h0000);
            wait_neg(1);
            check("sum_clear", sum_of(k), 16'h0000);
            // Only the falling filter armed, rise filter shut
            send(1'b1, 9 + kk, 16'h0000, 16'h0000);
            send(1'b1, 12 + kk, bv, 16'h0000);
            idle();
            pins[k] = 1'b0;
            wait_neg(4);
            check("event_fall", ev_of(k), bv);
            wait_neg(6);
            check("event_held", ev_of(k), bv);
            send(1'b1, 3 + kk, 16'h0000, 16'h0000);
            send(1'b0, 6 + kk, 16'h0000, bv);
            send(1'b1, 9 + kk, 16'hFFFF, 16'h0000);
            send(1'b1, 12 + kk, 16'h0000, 16'h0000);
            idle();
            check("event_gone", ev_of(k), 16'h0000);
        end
        wait_neg(3);
        final_report();
    end
endmodule : status_event_enable_structure_test
